// >>> design/pim_pkg.sv
/*
 * constants, types and register map of the pin interrupt and pattern
 * match block. assumes a 25 MHz system clock and an ahb-lite host.
 */
package pim_pkg;
    localparam int NCH = 8;
    localparam int NPIN = 64;
    localparam int SEL_W = 6;
    localparam int SRC_W = 3;
    localparam int COND_W = 3;
    localparam int CLK_NS = 40;
    // byte offsets of the registers
    localparam logic [5:0] OFS_MODE = 6'h00;
    localparam logic [5:0] OFS_RISE_EN = 6'h04;
    localparam logic [5:0] OFS_FALL_EN = 6'h08;
    localparam logic [5:0] OFS_RISE_FLAG = 6'h0c;
    localparam logic [5:0] OFS_FALL_FLAG = 6'h10;
    localparam logic [5:0] OFS_CHAN_STATE = 6'h14;
    localparam logic [5:0] OFS_PM_CTRL = 6'h18;
    localparam logic [5:0] OFS_PM_SRC = 6'h1c;
    localparam logic [5:0] OFS_PM_END = 6'h20;
    localparam logic [5:0] OFS_PM_COND = 6'h24;
    localparam logic [5:0] OFS_INT_STAT = 6'h28;
    localparam logic [5:0] OFS_INT_MASK = 6'h2c;
    // field positions
    localparam int CTRL_PM_EN_BIT = 0;
    localparam int CTRL_EV_EN_BIT = 1;
    localparam int STAT_TERM_LSB = 8;
    // values after reset, then the fixed end of the last slice
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [23:0] RST_SRC = 24'h000000;
    localparam logic [7:0] RST_END = 8'h00;
    localparam logic [23:0] RST_COND = 24'h000000;
    localparam logic [15:0] RST_STAT = 16'h0000;
    localparam logic [7:0] LAST_SLICE = 8'h80;

    typedef enum logic [2:0] {
        COND_CONST_HIGH = 3'h0,
        COND_RISE_STICKY = 3'h1,
        COND_FALL_STICKY = 3'h2,
        COND_EDGE_STICKY = 3'h3,
        COND_LEVEL_HIGH = 3'h4,
        COND_LEVEL_LOW = 3'h5,
        COND_CONST_LOW = 3'h6,
        COND_EDGE_EVENT = 3'h7
    } pim_cond_e;

    typedef struct packed {
        logic act;
        logic wr;
        logic [5:0] addr;
    } pim_dphase_s;
endpackage : pim_pkg

// >>> design/pim_top.sv
/*
 * pin interrupt channels and boolean pattern match engine with an
 * ahb-lite register slave. assumes pin selections come from the system
 * configuration block and pins are asynchronous to clk.
 */
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - eight channels, each fed from one pin chosen among all pins
// - channel selection only samples pins, never disturbs their function
// - pin choice per channel comes from the system configuration block
// - each channel edge or level mode, own request line
// - edge mode: rising, falling or both edges
// - level mode: request while pin high or while pin low
// - channel requests can wake the device with clock stopped
// - sum of product terms over eight slices, levels and transitions
// - each product term raises its own request
// - a rise of the combined match can pulse the cpu event input when enabled
// - pattern engine is not a wake source, runs on clk
// - registers answer in a single cycle, no wait states while clk_en is high
// - combined match result is an output routable to a pin
module pim_top (
    // clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // pins and channel pin selection
    input wire logic [pim_pkg::NPIN-1:0] pin_in,
    input wire logic [pim_pkg::NCH-1:0][pim_pkg::SEL_W-1:0] chan_pin_sel,
    // requests and events
    output logic [pim_pkg::NCH-1:0] chan_irq,
    output logic [pim_pkg::NCH-1:0] chan_wake,
    output logic [pim_pkg::NCH-1:0] term_irq,
    output logic cpu_event_notify,
    output logic pattern_match_output,
    output logic irq
);
    localparam int N = pim_pkg::NCH;

    function automatic logic slice_ok(input logic [2:0] c, input logic lvl,
        input logic rs, input logic fs, input logic r, input logic f);
        pim_pkg::pim_cond_e ce;
        ce = pim_pkg::pim_cond_e'(c);
        unique case (ce)
            pim_pkg::COND_CONST_HIGH: slice_ok = 1'b1;
            pim_pkg::COND_RISE_STICKY: slice_ok = rs;
            pim_pkg::COND_FALL_STICKY: slice_ok = fs;
            pim_pkg::COND_EDGE_STICKY: slice_ok = rs | fs;
            pim_pkg::COND_LEVEL_HIGH: slice_ok = lvl;
            pim_pkg::COND_LEVEL_LOW: slice_ok = ~lvl;
            pim_pkg::COND_CONST_LOW: slice_ok = 1'b0;
            pim_pkg::COND_EDGE_EVENT: slice_ok = r | f;
        endcase
    endfunction : slice_ok

    logic [pim_pkg::NPIN-1:0] pin_meta_r, pin_sync_r;
    logic [N-1:0] mode_r, rise_en_r, fall_en_r, rise_flag_r, fall_flag_r;
    logic [N-1:0] chan_prev_r, chan_irq_r, term_irq_r;
    logic [N-1:0] pm_rise_st_r, pm_fall_st_r;
    logic [1:0] pm_ctrl_r;
    logic [23:0] pm_src_r, pm_cond_r;
    logic [7:0] pm_end_r;
    logic [15:0] int_stat_r, int_mask_r;
    logic match_r, event_r;
    pim_pkg::pim_dphase_s dph_r;

    // bus decode; zero wait states while enabled
    wire ap_take = hsel & htrans[1] & hready & clk_en;
    wire wr_en = dph_r.act & dph_r.wr & clk_en;
    wire rd_en = dph_r.act & ~dph_r.wr & clk_en;
    wire [7:0] wd = hwdata[7:0];
    wire wr_mode = wr_en & (dph_r.addr == pim_pkg::OFS_MODE);
    wire wr_rise_en = wr_en & (dph_r.addr == pim_pkg::OFS_RISE_EN);
    wire wr_fall_en = wr_en & (dph_r.addr == pim_pkg::OFS_FALL_EN);
    wire wr_rflag = wr_en & (dph_r.addr == pim_pkg::OFS_RISE_FLAG);
    wire wr_fflag = wr_en & (dph_r.addr == pim_pkg::OFS_FALL_FLAG);
    wire wr_cstate = wr_en & (dph_r.addr == pim_pkg::OFS_CHAN_STATE);
    wire wr_ctrl = wr_en & (dph_r.addr == pim_pkg::OFS_PM_CTRL);
    wire wr_src = wr_en & (dph_r.addr == pim_pkg::OFS_PM_SRC);
    wire wr_end = wr_en & (dph_r.addr == pim_pkg::OFS_PM_END);
    wire wr_cond = wr_en & (dph_r.addr == pim_pkg::OFS_PM_COND);
    wire wr_mask = wr_en & (dph_r.addr == pim_pkg::OFS_INT_MASK);
    wire rd_stat = rd_en & (dph_r.addr == pim_pkg::OFS_INT_STAT);
    wire pm_cfg_wr = wr_src | wr_end | wr_cond;

    assign hreadyout = clk_en;
    assign hresp = 1'b0;

    // channel inputs and edges
    logic [N-1:0] chan_in, chan_raw;
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_chan
            // pins are only sampled, so the pin's own function is untouched
            assign chan_in[gi] = pin_sync_r[chan_pin_sel[gi]];
            assign chan_raw[gi] = pin_in[chan_pin_sel[gi]];
        end
    endgenerate
    wire [N-1:0] rise_seen = chan_in & ~chan_prev_r;
    wire [N-1:0] fall_seen = ~chan_in & chan_prev_r;
    wire [N-1:0] rise_set = rise_seen & rise_en_r & ~mode_r;
    wire [N-1:0] fall_set = fall_seen & fall_en_r & ~mode_r;
    wire [N-1:0] rise_clr = (wr_rflag | wr_cstate) ? wd : 8'h00;
    wire [N-1:0] fall_clr = (wr_fflag | wr_cstate) ? wd : 8'h00;
    wire [N-1:0] rise_flag_nxt = (rise_flag_r & ~rise_clr) | rise_set;
    wire [N-1:0] fall_flag_nxt = (fall_flag_r & ~fall_clr) | fall_set;
    // level mode: enable in rise_en, polarity in fall_en (1 = high active)
    wire [N-1:0] lvl_act = rise_en_r & ~(chan_in ^ fall_en_r);
    wire [N-1:0] chan_req =
        (mode_r & lvl_act) | (~mode_r & (rise_flag_r | fall_flag_r));
    // wake path is combinational from the raw pin so it works unclocked
    assign chan_wake = (mode_r & rise_en_r & ~(chan_raw ^ fall_en_r))
        | (~mode_r & ((rise_en_r & chan_raw & ~chan_prev_r)
        | (fall_en_r & ~chan_raw & chan_prev_r)
        | rise_flag_r | fall_flag_r));

    // pattern match slices, all on the clocked samples
    logic [N-1:0] s_in, s_prev, s_ok, run;
    wire [N-1:0] ends = pm_end_r | pim_pkg::LAST_SLICE;
    generate
        for (gi = 0; gi < N; gi++) begin : g_slice
            assign s_in[gi] = chan_in[pm_src_r[gi*pim_pkg::SRC_W +: 3]];
            assign s_prev[gi] = chan_prev_r[pm_src_r[gi*pim_pkg::SRC_W +: 3]];
            assign s_ok[gi] = slice_ok(pm_cond_r[gi*pim_pkg::COND_W +: 3],
                s_in[gi], pm_rise_st_r[gi], pm_fall_st_r[gi],
                s_in[gi] & ~s_prev[gi], ~s_in[gi] & s_prev[gi]);
            if (gi == 0) begin : g_first
                assign run[gi] = s_ok[gi];
            end else begin : g_next
                assign run[gi] = s_ok[gi] & (ends[gi-1] | run[gi-1]);
            end
        end
    endgenerate
    wire [N-1:0] s_rise = s_in & ~s_prev;
    wire [N-1:0] s_fall = ~s_in & s_prev;
    wire pm_en = pm_ctrl_r[pim_pkg::CTRL_PM_EN_BIT];
    wire [N-1:0] term_now = run & ends & {N{pm_en}};
    wire match_nxt = |term_now;
    wire event_nxt = match_nxt & ~match_r
        & pm_ctrl_r[pim_pkg::CTRL_EV_EN_BIT];
    // config write restarts the sticky edges; an edge in that cycle counts
    wire [N-1:0] pm_rise_st_nxt = (pm_cfg_wr ? 8'h00 : pm_rise_st_r) | s_rise;
    wire [N-1:0] pm_fall_st_nxt = (pm_cfg_wr ? 8'h00 : pm_fall_st_r) | s_fall;

    // sticky interrupt status; a new event wins over the read clear
    wire [15:0] int_ev = {term_now & ~term_irq_r, chan_req & ~chan_irq_r};
    wire [15:0] int_stat_nxt =
        (rd_stat ? 16'h0000 : int_stat_r) | int_ev;

    // read data
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h00000000;
        unique case (dph_r.addr)
            pim_pkg::OFS_MODE: rd_word = {24'h000000, mode_r};
            pim_pkg::OFS_RISE_EN: rd_word = {24'h000000, rise_en_r};
            pim_pkg::OFS_FALL_EN: rd_word = {24'h000000, fall_en_r};
            pim_pkg::OFS_RISE_FLAG: rd_word = {24'h000000, rise_flag_r};
            pim_pkg::OFS_FALL_FLAG: rd_word = {24'h000000, fall_flag_r};
            pim_pkg::OFS_CHAN_STATE: rd_word = {16'h0000, chan_in, chan_irq_r};
            pim_pkg::OFS_PM_CTRL: rd_word = {16'h0000, term_irq_r, 6'h00,
                pm_ctrl_r};
            pim_pkg::OFS_PM_SRC: rd_word = {8'h00, pm_src_r};
            pim_pkg::OFS_PM_END: rd_word = {24'h000000, pm_end_r};
            pim_pkg::OFS_PM_COND: rd_word = {8'h00, pm_cond_r};
            pim_pkg::OFS_INT_STAT: rd_word = {16'h0000, int_stat_r};
            pim_pkg::OFS_INT_MASK: rd_word = {16'h0000, int_mask_r};
            default: rd_word = 32'h00000000;
        endcase
    end
    assign hrdata = (dph_r.act & ~dph_r.wr) ? rd_word : 32'h00000000;

    // two-flop pin synchroniser, then one sample kept for edges
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            chan_prev_r <= '0;
        end else if (clk_en) begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
            chan_prev_r <= chan_in;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dph_r <= '0;
        end else if (clk_en) begin
            dph_r <= '{act: ap_take, wr: hwrite, addr: haddr[5:0]};
        end
    end

    // writes land at the end of the data phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_r <= pim_pkg::RST_BYTE;
            rise_en_r <= pim_pkg::RST_BYTE;
            fall_en_r <= pim_pkg::RST_BYTE;
            pm_ctrl_r <= pim_pkg::RST_CTRL;
            pm_src_r <= pim_pkg::RST_SRC;
            pm_end_r <= pim_pkg::RST_END;
            pm_cond_r <= pim_pkg::RST_COND;
            int_mask_r <= pim_pkg::RST_STAT;
        end else begin
            if (wr_mode) mode_r <= wd;
            if (wr_rise_en) rise_en_r <= wd;
            if (wr_fall_en) fall_en_r <= wd;
            if (wr_ctrl) pm_ctrl_r <= hwdata[1:0];
            if (wr_src) pm_src_r <= hwdata[23:0];
            if (wr_end) pm_end_r <= wd;
            if (wr_cond) pm_cond_r <= hwdata[23:0];
            if (wr_mask) int_mask_r <= hwdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rise_flag_r <= pim_pkg::RST_BYTE;
            fall_flag_r <= pim_pkg::RST_BYTE;
            chan_irq_r <= pim_pkg::RST_BYTE;
            term_irq_r <= pim_pkg::RST_BYTE;
            pm_rise_st_r <= pim_pkg::RST_BYTE;
            pm_fall_st_r <= pim_pkg::RST_BYTE;
            int_stat_r <= pim_pkg::RST_STAT;
            match_r <= 1'b0;
            event_r <= 1'b0;
        end else if (clk_en) begin
            rise_flag_r <= rise_flag_nxt;
            fall_flag_r <= fall_flag_nxt;
            chan_irq_r <= chan_req;
            term_irq_r <= term_now;
            pm_rise_st_r <= pm_rise_st_nxt;
            pm_fall_st_r <= pm_fall_st_nxt;
            int_stat_r <= int_stat_nxt;
            match_r <= match_nxt;
            event_r <= event_nxt;
        end
    end

    // request outputs straight from flops; irq is the masked or of the status flops
    assign chan_irq = chan_irq_r;
    assign term_irq = term_irq_r;
    assign pattern_match_output = match_r;
    assign cpu_event_notify = event_r;
    assign irq = |(int_stat_r & int_mask_r);

    // checks run on clk; reset masks them
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_sync_two_flops: assert property (
        clk_en ##1 clk_en |=> pin_sync_r == $past(pin_in, 2))
        else $error("pin sample not two flops behind the pin");
    a_edge_flag_sets: assert property (
        clk_en && (rise_set != 8'h00) |=> (rise_flag_r & $past(rise_set))
        == $past(rise_set))
        else $error("enabled rising edge did not set its flag");
    a_flag_holds: assert property (
        clk_en && rise_flag_r[0] && !wr_rflag && !wr_cstate |=> rise_flag_r[0])
        else $error("edge flag dropped without a clear write");
    a_level_follows: assert property (
        clk_en && mode_r[3] && rise_en_r[3] && (chan_in[3] == fall_en_r[3])
        |=> chan_irq[3])
        else $error("level request missing while pin active");
    a_level_unlatched: assert property (
        clk_en && mode_r[3] && (chan_in[3] != fall_en_r[3]) |=> !chan_irq[3])
        else $error("level request held after pin went inactive");
    a_term_request: assert property (
        clk_en |=> term_irq == $past(term_now))
        else $error("term request does not follow its term");
    a_event_single: assert property (
        cpu_event_notify && $past(clk_en) |-> pattern_match_output
        && !$past(pattern_match_output) && pm_ctrl_r[pim_pkg::CTRL_EV_EN_BIT])
        else $error("event pulse without a new match");
    a_match_output: assert property (
        clk_en |=> pattern_match_output == (|$past(term_now)))
        else $error("match output not the or of the terms");
    a_zero_wait: assert property (
        ap_take ##1 clk_en |-> hreadyout && !hresp)
        else $error("register access took a wait state");
    a_wake_flags: assert property (
        ((~mode_r & (rise_flag_r | fall_flag_r)) & ~chan_wake) == 8'h00)
        else $error("set edge flag without a wake request");

    c_edge_irq: cover property (clk_en && |rise_set ##1 chan_irq != 8'h00);
    c_level_irq: cover property (mode_r[3] && chan_irq[3]);
    c_frozen: cover property (!clk_en ##1 !clk_en && chan_irq[3]);
    c_term_event: cover property (cpu_event_notify ##1 term_irq != 8'h00);
    c_irq_read: cover property (irq ##1 rd_stat);
endmodule : pim_top

// >>> verif/pim_cpu_model.sv
/* core interrupt controller and event input model: latches the rise of
   each channel request as pending and counts event pulses on clk. */
`timescale 1ns/1ps
module pim_cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // requests from the block
    input wire logic [pim_pkg::NCH-1:0] chan_irq,
    input wire logic cpu_event_notify,
    // what the core has taken
    output logic [pim_pkg::NCH-1:0] chan_pend,
    output logic [7:0] ev_count
);
    logic [pim_pkg::NCH-1:0] chan_q;
    always_ff @(posedge clk) begin
        chan_q <= chan_irq;
        chan_pend <= sys_rst ? '0 : chan_pend | (chan_irq & ~chan_q);
        ev_count <= sys_rst ? 8'h00 : ev_count + 8'(cpu_event_notify);
    end
endmodule : pim_cpu_model

// >>> verif/pim_top_tb.sv
/* self-checking bench of pim_top with a core model on the request lines.
   assumes a zero-wait ahb-lite slave and the package register map. */
`timescale 1ns/1ps
module pim_top_tb;
    logic clk, sys_rst, clk_en, hsel, hwrite, rdy_q, hreadyout, hresp;
    logic irq, cpu_event_notify, pattern_match_output;
    logic [31:0] haddr, hwdata, hrdata, rd_q, v;
    logic [1:0] htrans;
    logic [63:0] pin_in;
    logic [7:0][5:0] chan_pin_sel;
    logic [7:0] chan_irq, chan_wake, term_irq, chan_pend, ev_count;
    int n_fail = 0, samples_checked = 0, seed = 32'h73b7;
    pim_top pim_top_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in(pin_in), .chan_pin_sel(chan_pin_sel), .chan_irq(chan_irq),
        .chan_wake(chan_wake), .term_irq(term_irq),
        .cpu_event_notify(cpu_event_notify),
        .pattern_match_output(pattern_match_output), .irq(irq));
    pim_cpu_model pim_cpu_model_i (.clk(clk), .sys_rst(sys_rst),
        .chan_irq(chan_irq), .cpu_event_notify(cpu_event_notify),
        .chan_pend(chan_pend), .ev_count(ev_count));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        rd_q <= hrdata;
        rdy_q <= hreadyout;
    end
    task results;
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        hsel <= 1'b1;
        haddr <= {26'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        for (int ph = 0; ph < 2; ph++) begin
            k = 0;
            do begin
                tick(1);
                k++;
            end while (rdy_q !== 1'b1 && k < 16);
            chk("wait states", k, 1);
            chk("response", hresp, 0);
            if (k == 16)
                results();
            if (ph == 0) begin
                hsel <= 1'b0;
                htrans <= 2'h0;
                hwdata <= d;
            end
        end
        v = rd_q;
    endtask : bus
    task rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, $random(seed));
        chk(nm, v, e);
    endtask : rdc
    task setp(input logic [7:0] m, input logic val);
        logic [63:0] p;
        p = pin_in;
        for (int c = 0; c < 8; c++)
            if (m[c]) p[chan_pin_sel[c]] = val;
        pin_in <= p;
    endtask : setp
    function logic exp_term(input logic [2:0] c, input logic hi);
        case (c)
            pim_pkg::COND_CONST_HIGH: return 1'b1;
            pim_pkg::COND_LEVEL_HIGH: return hi;
            pim_pkg::COND_LEVEL_LOW, pim_pkg::COND_FALL_STICKY,
                pim_pkg::COND_EDGE_STICKY: return !hi;
            default: return 1'b0;
        endcase
    endfunction : exp_term
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata, pin_in} = '0;
        for (int i = 0; i < 8; i++)
            chan_pin_sel[i] = {3'(i), 3'($random(seed))};
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        tick(1);
        for (int i = 0; i < 12; i++)
            rdc("reset", 6'(4 * i), 0);
        bus(1'b1, 6'h30, $random(seed));
        rdc("unmapped", 6'h30, 0);
        bus(1'b1, pim_pkg::OFS_INT_MASK, 32'h100);
        bus(1'b1, pim_pkg::OFS_RISE_EN, 32'h05);
        bus(1'b1, pim_pkg::OFS_FALL_EN, 32'h06);
        setp(8'h07, 1'b1);
        tick(3);
        chk("sync", chan_irq, 0);
        tick(1);
        chk("rise irq", chan_irq, 8'h05);
        chk("masked", irq, 0);
        bus(1'b1, pim_pkg::OFS_INT_MASK, 32'h101);
        chk("unmasked", irq, 1);
        rdc("rise flag", pim_pkg::OFS_RISE_FLAG, 32'h05);
        setp(8'h07, 1'b0);
        tick(6);
        rdc("fall flag", pim_pkg::OFS_FALL_FLAG, 32'h06);
        chk("sticky", chan_irq, 8'h07);
        chk("pending", chan_pend, 8'h07);
        rdc("status", pim_pkg::OFS_INT_STAT, 32'h07);
        chk("read clear", irq, 0);
        bus(1'b1, pim_pkg::OFS_RISE_FLAG, 32'h01);
        tick(1);
        chk("w1c", chan_irq, 8'h06);
        bus(1'b1, pim_pkg::OFS_MODE, 32'h18);
        bus(1'b1, pim_pkg::OFS_RISE_EN, 32'h1d);
        bus(1'b1, pim_pkg::OFS_FALL_EN, 32'h0e);
        tick(2);
        chk("level low", chan_irq[4:3], 2'b10);
        setp(8'h08, 1'b1);
        tick(1);
        chk("wake", chan_wake[3], 1);
        tick(4);
        chk("level high", chan_irq[4:3], 2'b11);
        bus(1'b0, pim_pkg::OFS_INT_STAT, 0);
        bus(1'b1, pim_pkg::OFS_PM_END, 32'h01);
        bus(1'b1, pim_pkg::OFS_PM_COND, {21'h1b6db6, 3'h4});
        bus(1'b1, pim_pkg::OFS_PM_CTRL, 32'h03);
        setp(8'h01, 1'b1);
        tick(8);
        chk("term", term_irq, 8'h01);
        chk("match out", pattern_match_output, 1);
        chk("event", ev_count, 1);
        rdc("term stat", pim_pkg::OFS_INT_STAT, 32'h0101);
        bus(1'b1, pim_pkg::OFS_PM_CTRL, 32'h01);
        for (int c = 0; c < 8; c++) begin
            setp(8'h01, 1'b1);
            tick(6);
            bus(1'b1, pim_pkg::OFS_PM_COND, {21'h1b6db6, 3'(c)});
            tick(4);
            chk("cond high", term_irq[0], exp_term(3'(c), 1'b1));
            setp(8'h01, 1'b0);
            tick(6);
            chk("cond low", term_irq[0], exp_term(3'(c), 1'b0));
        end
        bus(1'b0, pim_pkg::OFS_INT_STAT, 0);
        setp(8'h01, 1'b1);
        tick(6);
        rdc("edge term", pim_pkg::OFS_INT_STAT, 32'h0100);
        setp(8'h01, 1'b0);
        tick(6);
        bus(1'b1, pim_pkg::OFS_PM_COND, {21'h1b6db6, 3'h1});
        tick(4);
        chk("sticky cleared", term_irq[0], 0);
        setp(8'h01, 1'b1);
        tick(6);
        chk("sticky rise", term_irq[0], 1);
        clk_en <= 1'b0;
        setp(8'h08, 1'b0);
        tick(6);
        chk("frozen", chan_irq[3], 1);
        chk("stall", hreadyout, 0);
        chk("wake unclocked", chan_wake[3], 0);
        clk_en <= 1'b1;
        tick(6);
        chk("level drop", chan_irq[3], 0);
        chk("no event", ev_count, 1);
        results();
    end
endmodule : pim_top_tb
